// file: core/asm_lat_if.sv
// carrier between a monitor and its fault latch
`timescale 1ns/1ps
interface asm_lat_if;
    logic viol;
    logic ack;
    logic hold;
    logic flt;
    modport mon (output viol, output ack, output hold, input flt);
    modport lat (input viol, input ack, input hold, output flt);
endinterface

// file: core/asm_latch.sv
// sticky fault latch with guarded acknowledge
`timescale 1ns/1ps
module asm_latch import asm_pkg::*; (
    input wire logic mclk,
    input wire logic rst_n,
    asm_lat_if.lat lif
);
    logic flt_q;
    logic flt_d;

    always_comb begin
        flt_d = lif.viol | (flt_q & ~(lif.ack & ~lif.hold));
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flt_q <= 1'b0;
        end else begin
            flt_q <= flt_d;
        end
    end

    assign lif.flt = flt_q;
endmodule

// file: core/asm_pkg.sv
// constants and types for the axis motion safety monitors
// What this block does
// - increment output high when direction matches and travel does not exceed step limit
// - increment output low on contrary direction or travel above step limit
// - relative travel accumulates from movement start, compared with step limit
// - reverse position tolerance lets small reverse travel and creep pass
// - direction monitor derives sense of rotation from speed each evaluation
// - direction output high when sign matches marker, low when contrary
// - direction faults only past separate speed and position tolerances, or on any sample with both direction inputs high
// - both direction inputs high while monitor enabled raises an alarm
// - violations latch; inport, panel key or fieldbus reset clears them once monitor enable and, for inc/dir, direction inputs are low
// - speed output high below speed threshold, low at or above it
// - permanent activation makes speed monitor active without sls_enable once its control bit is written (clear after reset)
// - speed change above maximum acceleration is a speed violation
// - ramp supervision adds stop-ramp monitor result to speed evaluation
// - overspeed integrator rises above threshold, falls below it
// - integrator above fault distance triggers the speed fault
// - overspeed distance works only with acceleration monitoring off
// - fast channel drives speed result straight to the fast output
// - ramp supervision starts stop-ramp monitor while speed above threshold
// - threshold of zero or below with ramp supervision gives emergency stop
package asm_pkg;
    localparam int ASM_W = 16;
    localparam int ASM_AW = 32;
    localparam logic [5:0] ASM_OFS_CTRL = 6'h00;
    localparam logic [5:0] ASM_OFS_STEP = 6'h04;
    localparam logic [5:0] ASM_OFS_XI = 6'h08;
    localparam logic [5:0] ASM_OFS_DSPD = 6'h0C;
    localparam logic [5:0] ASM_OFS_DPOS = 6'h10;
    localparam logic [5:0] ASM_OFS_THR = 6'h14;
    localparam logic [5:0] ASM_OFS_ACC = 6'h18;
    localparam logic [5:0] ASM_OFS_DIST = 6'h1C;
    localparam logic [5:0] ASM_OFS_STAT = 6'h20;
    localparam logic [5:0] ASM_OFS_TRV = 6'h24;
    localparam logic [5:0] ASM_OFS_INTG = 6'h28;
    localparam int ASM_CTRL_PERM = 0;
    localparam int ASM_CTRL_ACC = 1;
    localparam int ASM_CTRL_OVD = 2;
    localparam int ASM_CTRL_RAMP = 3;
    localparam int ASM_CTRL_FAST = 4;
    localparam logic [4:0] ASM_CTRL_RST = 5'h00;
    localparam logic [31:0] ASM_CFG_RST = 32'h0000_0000;
    typedef enum logic [0:0] {
        ASM_BUS_IDLE = 1'b0,
        ASM_BUS_ACK = 1'b1
    } asm_bus_st_t;
endpackage

// file: core/asm_top.sv
// axis motion safety monitors with avalon register slave
//
// The implementer's own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module asm_top import asm_pkg::*; #(
    parameter int W = ASM_W,
    parameter int AW = ASM_AW
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic sample_valid,
    input wire logic signed [W-1:0] pos_in,
    input wire logic signed [W-1:0] spd_in,
    input wire logic dir_right_input,
    input wire logic dir_left_input,
    input wire logic inc_enable,
    input wire logic dir_enable,
    input wire logic sls_enable,
    input wire logic ramp_fault_in,
    input wire logic inport_reset,
    input wire logic panel_key_reset,
    input wire logic fieldbus_reset_source,
    output logic inc_ok,
    output logic dir_ok,
    output logic sls_ok,
    output logic fast_out,
    output logic ramp_activate,
    output logic estop,
    output logic alarm
);
    ////////////////////////////////////////////////////////////////////////
    // reset release
    logic rs1_q;
    logic rst_n;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rs1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rst_n <= rs1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register bus
    asm_bus_st_t bus_q;
    logic [4:0] ctrl_q;
    logic [AW-1:0] step_q;
    logic [AW-1:0] xi_q;
    logic [AW-1:0] dspd_q;
    logic [AW-1:0] dpos_q;
    logic [AW-1:0] thr_q;
    logic [AW-1:0] acc_q;
    logic [AW-1:0] dist_q;
    logic [AW-1:0] trv_q;
    logic [AW-1:0] intg_q;
    logic [31:0] stat;
    logic [31:0] rd_mux;
    logic wr_go;
    logic [31:0] ctrl_m;

    function automatic logic [31:0] be_merge(input logic [31:0] o,
                                             input logic [31:0] n,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = n[i*8 +: 8];
            end
        end
        return r;
    endfunction

    assign avs_waitrequest = (avs_read | avs_write) & (bus_q != ASM_BUS_ACK);
    assign wr_go = avs_write & (bus_q == ASM_BUS_ACK);
    assign ctrl_m = be_merge({27'h0, ctrl_q}, avs_writedata,
        avs_byteenable);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bus_q <= ASM_BUS_IDLE;
        end else begin
            case (bus_q)
                ASM_BUS_IDLE: begin
                    if (avs_read | avs_write) begin
                        bus_q <= ASM_BUS_ACK;
                    end
                end
                ASM_BUS_ACK: bus_q <= ASM_BUS_IDLE;
                default: bus_q <= ASM_BUS_IDLE;
            endcase
        end
    end

    always_comb begin
        case (avs_address)
            ASM_OFS_CTRL: rd_mux = {27'h0, ctrl_q};
            ASM_OFS_STEP: rd_mux = step_q;
            ASM_OFS_XI: rd_mux = xi_q;
            ASM_OFS_DSPD: rd_mux = dspd_q;
            ASM_OFS_DPOS: rd_mux = dpos_q;
            ASM_OFS_THR: rd_mux = thr_q;
            ASM_OFS_ACC: rd_mux = acc_q;
            ASM_OFS_DIST: rd_mux = dist_q;
            ASM_OFS_STAT: rd_mux = stat;
            ASM_OFS_TRV: rd_mux = trv_q;
            ASM_OFS_INTG: rd_mux = intg_q;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && bus_q == ASM_BUS_IDLE) begin
            avs_readdata <= rd_mux;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= ASM_CTRL_RST;
            step_q <= ASM_CFG_RST;
            xi_q <= ASM_CFG_RST;
            dspd_q <= ASM_CFG_RST;
            dpos_q <= ASM_CFG_RST;
            thr_q <= ASM_CFG_RST;
            acc_q <= ASM_CFG_RST;
            dist_q <= ASM_CFG_RST;
        end else if (wr_go) begin
            case (avs_address)
                ASM_OFS_CTRL: ctrl_q <= ctrl_m[4:0];
                ASM_OFS_STEP: step_q <= be_merge(step_q, avs_writedata,
                    avs_byteenable);
                ASM_OFS_XI: xi_q <= be_merge(xi_q, avs_writedata,
                    avs_byteenable);
                ASM_OFS_DSPD: dspd_q <= be_merge(dspd_q, avs_writedata,
                    avs_byteenable);
                ASM_OFS_DPOS: dpos_q <= be_merge(dpos_q, avs_writedata,
                    avs_byteenable);
                ASM_OFS_THR: thr_q <= be_merge(thr_q, avs_writedata,
                    avs_byteenable);
                ASM_OFS_ACC: acc_q <= be_merge(acc_q, avs_writedata,
                    avs_byteenable);
                ASM_OFS_DIST: dist_q <= be_merge(dist_q, avs_writedata,
                    avs_byteenable);
                default: ctrl_q <= ctrl_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shared evaluation terms
    logic signed [AW-1:0] pos_prev_q;
    logic signed [AW-1:0] spd_prev_q;
    logic signed [AW-1:0] pos_x;
    logic signed [AW-1:0] spd_x;
    logic signed [AW-1:0] dlt;
    logic signed [AW-1:0] fwd;
    logic [AW-1:0] fwd_abs;
    logic [AW-1:0] spd_abs;
    logic [AW-1:0] opp_spd;
    logic [AW-1:0] dacc;
    logic one_dir;
    logic both_dir;
    logic sense_neg;
    logic ack_any;

    assign pos_x = AW'(pos_in);
    assign spd_x = AW'(spd_in);
    assign one_dir = dir_right_input ^ dir_left_input;
    assign both_dir = dir_right_input & dir_left_input;
    assign ack_any = inport_reset | panel_key_reset | fieldbus_reset_source;

    always_comb begin
        dlt = pos_x - pos_prev_q;
        fwd = dir_right_input ? dlt : -dlt;
        fwd_abs = fwd[AW-1] ? AW'(-fwd) : AW'(fwd);
        sense_neg = spd_in[W-1];
        spd_abs = sense_neg ? AW'(-spd_x) : AW'(spd_x);
        if (!one_dir) begin
            opp_spd = spd_abs;
        end else if (dir_right_input) begin
            opp_spd = sense_neg ? spd_abs : '0;
        end else begin
            opp_spd = sense_neg ? '0 : spd_abs;
        end
        dacc = (spd_x >= spd_prev_q) ? AW'(spd_x - spd_prev_q)
                                     : AW'(spd_prev_q - spd_x);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pos_prev_q <= '0;
            spd_prev_q <= '0;
        end else if (sample_valid) begin
            pos_prev_q <= pos_x;
            spd_prev_q <= spd_x;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // limited increment monitor
    asm_lat_if inc_lif();
    asm_lat_if dir_lif();
    asm_lat_if sls_lif();
    logic [AW-1:0] rev_q;
    logic [AW-1:0] trv_d;
    logic [AW-1:0] rev_d;
    logic inc_val_q;

    always_comb begin
        if (one_dir && !fwd[AW-1]) begin
            trv_d = trv_q + fwd_abs;
            rev_d = rev_q;
        end else begin
            trv_d = trv_q;
            rev_d = rev_q + fwd_abs;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            trv_q <= '0;
            rev_q <= '0;
            inc_val_q <= 1'b0;
        end else if (!inc_enable) begin
            trv_q <= '0;
            rev_q <= '0;
            inc_val_q <= 1'b0;
        end else if (sample_valid) begin
            trv_q <= trv_d;
            rev_q <= rev_d;
            inc_val_q <= 1'b1;
        end
    end

    assign inc_lif.viol = sample_valid & inc_enable &
        ((trv_d > step_q) | (rev_d > xi_q) | both_dir);
    assign inc_lif.ack = ack_any;
    assign inc_lif.hold = dir_right_input | dir_left_input | inc_enable;

    asm_latch u_inc_lat (
        .mclk(mclk),
        .rst_n(rst_n),
        .lif(inc_lif)
    );

    ////////////////////////////////////////////////////////////////////////
    // direction monitor
    logic [AW-1:0] drev_q;
    logic [AW-1:0] drev_d;
    logic dir_val_q;

    assign drev_d = (one_dir && !fwd[AW-1]) ? drev_q : drev_q + fwd_abs;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            drev_q <= '0;
            dir_val_q <= 1'b0;
        end else if (!dir_enable) begin
            drev_q <= '0;
            dir_val_q <= 1'b0;
        end else if (sample_valid) begin
            drev_q <= drev_d;
            dir_val_q <= 1'b1;
        end
    end

    assign dir_lif.viol = sample_valid & dir_enable &
        ((opp_spd > dspd_q) | (drev_d > dpos_q) | both_dir);
    assign dir_lif.ack = ack_any;
    assign dir_lif.hold = dir_right_input | dir_left_input | dir_enable;

    asm_latch u_dir_lat (
        .mclk(mclk),
        .rst_n(rst_n),
        .lif(dir_lif)
    );

    ////////////////////////////////////////////////////////////////////////
    // limited speed monitor
    logic sls_act;
    logic sls_val_q;
    logic ovd_on;
    logic ramp_on;
    logic thr_bad;
    logic spd_exc;
    logic spd_above;
    logic spd_flt;
    logic signed [AW:0] intg_sum;
    logic [AW-1:0] intg_d;

    assign sls_act = ctrl_q[ASM_CTRL_PERM] | sls_enable;
    assign ovd_on = ctrl_q[ASM_CTRL_OVD] & ~ctrl_q[ASM_CTRL_ACC];
    assign ramp_on = ctrl_q[ASM_CTRL_RAMP] & sls_act;
    assign thr_bad = ramp_on & ($signed(thr_q) <= 0);
    assign spd_exc = spd_abs >= thr_q;
    assign spd_above = spd_abs > thr_q;

    always_comb begin
        intg_sum = $signed({1'b0, intg_q}) + $signed({1'b0, spd_abs})
                 - $signed({1'b0, thr_q});
        if (intg_sum[AW]) begin
            intg_d = '0;
        end else begin
            intg_d = intg_sum[AW-1:0];
        end
        if (ramp_on && spd_above) begin
            spd_flt = 1'b0;
        end else if (ovd_on) begin
            spd_flt = intg_d > dist_q;
        end else begin
            spd_flt = spd_exc;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            intg_q <= '0;
            sls_val_q <= 1'b0;
        end else if (!sls_act) begin
            intg_q <= '0;
            sls_val_q <= 1'b0;
        end else if (sample_valid) begin
            intg_q <= ovd_on ? intg_d : '0;
            sls_val_q <= 1'b1;
        end
    end

    assign sls_lif.viol = sample_valid & sls_act & (spd_flt | thr_bad |
        (ctrl_q[ASM_CTRL_ACC] & (dacc > acc_q)) |
        (ramp_on & ramp_fault_in));
    assign sls_lif.ack = ack_any;
    assign sls_lif.hold = sls_enable;

    asm_latch u_sls_lat (
        .mclk(mclk),
        .rst_n(rst_n),
        .lif(sls_lif)
    );

    ////////////////////////////////////////////////////////////////////////
    // outputs
    // low until first evaluation
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            inc_ok <= 1'b0;
            dir_ok <= 1'b0;
            sls_ok <= 1'b0;
        end else begin
            inc_ok <= inc_val_q & ~inc_lif.flt;
            dir_ok <= dir_val_q & ~dir_lif.flt;
            sls_ok <= sls_val_q & ~sls_lif.flt;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fast_out <= 1'b0;
        end else if (!ctrl_q[ASM_CTRL_FAST] || !sls_act) begin
            fast_out <= 1'b0;
        end else if (sls_lif.viol) begin
            fast_out <= 1'b0;
        end else if (sample_valid) begin
            fast_out <= ~sls_lif.flt;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ramp_activate <= 1'b0;
            estop <= 1'b0;
            alarm <= 1'b0;
        end else begin
            if (!ramp_on) begin
                ramp_activate <= 1'b0;
            end else if (sample_valid) begin
                ramp_activate <= spd_above;
            end
            estop <= thr_bad;
            alarm <= (inc_enable | dir_enable) & both_dir;
        end
    end

    assign stat = {23'h0, ramp_activate, estop, alarm, sls_lif.flt,
                   dir_lif.flt, inc_lif.flt, sls_ok, dir_ok, inc_ok};
endmodule

// file: tb/asm_enc_model.sv
// encoder interface model issuing one sample per request
`timescale 1ns/1ps
module asm_enc_model import asm_pkg::*; (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic signed [ASM_W-1:0] spd_set,
    output logic sample_valid,
    output logic signed [ASM_W-1:0] pos_in,
    output logic signed [ASM_W-1:0] spd_in
);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sample_valid <= 1'b0;
            pos_in <= 16'h0000;
            spd_in <= 16'h0000;
        end else begin
            sample_valid <= go;
            if (go) begin
                spd_in <= spd_set;
                pos_in <= pos_in + spd_set;
            end
        end
    end
endmodule

// file: tb/asm_properties.sv
// checker on the top ports of the motion monitors
`timescale 1ns/1ps
module asm_properties (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic sample_valid,
    input wire logic dir_right_input,
    input wire logic dir_left_input,
    input wire logic inc_enable,
    input wire logic dir_enable,
    input wire logic sls_enable,
    input wire logic inc_ok,
    input wire logic dir_ok,
    input wire logic sls_ok,
    input wire logic fast_out,
    input wire logic ramp_activate,
    input wire logic estop,
    input wire logic alarm
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////////
    a_reset_low: assert property (disable iff (1'b0)
        !arst_n [*2] |-> !(inc_ok | dir_ok | sls_ok | fast_out | alarm |
        estop | ramp_activate)) else $error("output high in reset");
    a_inc_rise: assert property ($rose(inc_ok) |->
        $past(sample_valid, 2) || $past(sample_valid, 3))
        else $error("inc ok rose without sample");
    a_sls_rise: assert property (sls_ok && !$past(sls_ok) |->
        $past(sample_valid, 2) || $past(sample_valid, 3))
        else $error("speed ok rose without sample");
    a_sls_hold: assert property ($fell(sls_ok) && sls_enable
        ##1 sls_enable |-> !sls_ok) else $error("speed fault not held");
    a_dir_hold: assert property ($fell(dir_ok) && dir_enable
        ##1 dir_enable [*2] |-> !dir_ok) else $error("dir fault not held");
    a_alarm_both: assert property (sample_valid && dir_enable &&
        dir_right_input && dir_left_input |-> ##[1:2] alarm)
        else $error("no alarm on both markers");
    a_fast_cause: assert property ($rose(fast_out) |->
        $past(sample_valid) || $past(avs_write) || $past(avs_write, 2))
        else $error("fast output rose without sample");
    a_en_low: assert property (!inc_enable [*2] ##1 inc_enable |->
        !inc_ok) else $error("inc ok high before sample");
    a_rd_hold: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data moved without read");
    c_alarm: cover property ($rose(alarm));
    c_sls_fault: cover property ($fell(sls_ok));
    c_ramp: cover property ($rose(ramp_activate));
endmodule
bind asm_top asm_properties asm_properties_inst (.mclk(mclk),
    .arst_n(arst_n), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .sample_valid(sample_valid),
    .dir_right_input(dir_right_input), .dir_left_input(dir_left_input),
    .inc_enable(inc_enable), .dir_enable(dir_enable),
    .sls_enable(sls_enable), .inc_ok(inc_ok), .dir_ok(dir_ok),
    .sls_ok(sls_ok), .fast_out(fast_out), .ramp_activate(ramp_activate),
    .estop(estop), .alarm(alarm));

// file: tb/tb.sv
// testbench for the motion monitors
`timescale 1ns/1ps
module tb import asm_pkg::*;;
    logic mclk;
    logic arst_n;
    logic [5:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic sample_valid;
    logic signed [ASM_W-1:0] pos_in;
    logic signed [ASM_W-1:0] spd_in;
    logic signed [ASM_W-1:0] spd_set;
    logic go;
    logic dir_right_input;
    logic dir_left_input;
    logic inc_enable;
    logic dir_enable;
    logic sls_enable;
    logic ramp_fault_in;
    logic [2:0] rsrc;
    logic [3:0] be;
    logic inc_ok;
    logic dir_ok;
    logic sls_ok;
    logic fast_out;
    logic ramp_activate;
    logic estop;
    logic alarm;
    logic [31:0] q;
    int n_mismatch;
    int checked;
    int tn;
    ////////////////////////////////////////////////////////////////////////
    asm_top asm_top_inst (.mclk(mclk), .arst_n(arst_n),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(be), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sample_valid(sample_valid),
        .pos_in(pos_in), .spd_in(spd_in), .dir_right_input(dir_right_input),
        .dir_left_input(dir_left_input), .inc_enable(inc_enable),
        .dir_enable(dir_enable), .sls_enable(sls_enable),
        .ramp_fault_in(ramp_fault_in), .inport_reset(rsrc[2]),
        .panel_key_reset(rsrc[1]), .fieldbus_reset_source(rsrc[0]),
        .inc_ok(inc_ok), .dir_ok(dir_ok), .sls_ok(sls_ok),
        .fast_out(fast_out), .ramp_activate(ramp_activate), .estop(estop),
        .alarm(alarm));
    asm_enc_model asm_enc_model_inst (.mclk(mclk), .rst_n(arst_n), .go(go),
        .spd_set(spd_set), .sample_valid(sample_valid), .pos_in(pos_in),
        .spd_in(spd_in));
    always #12.5 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////
    task close_out;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task cmp(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task cb(input logic g, input logic e);
        cmp({31'h0, g}, {31'h0, e});
    endtask
    task bus(input logic r, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= r;
        avs_write <= !r;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0 && n < 40) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 40) begin
            n_mismatch++;
            close_out;
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask
    task wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b0, a, d);
    endtask
    task rc(input logic [5:0] a, input logic [31:0] e);
        bus(1'b1, a, 32'h0);
        cmp(q, e);
    endtask
    task rb(input int i, input logic e);
        bus(1'b1, ASM_OFS_STAT, 32'h0);
        cb(q[i], e);
    endtask
    task smp(input logic signed [ASM_W-1:0] s, input int k);
        spd_set <= s;
        repeat (k) begin
            go <= 1'b1;
            @(posedge mclk);
            go <= 1'b0;
            repeat (3) @(posedge mclk);
        end
    endtask
    task pulse(input logic [2:0] k);
        rsrc <= k;
        @(posedge mclk);
        rsrc <= 3'h0;
        @(posedge mclk);
    endtask
    task clr(input logic [2:0] k);
        {inc_enable, dir_enable, sls_enable} <= 3'h0;
        {dir_right_input, dir_left_input} <= 2'h0;
        @(posedge mclk);
        pulse(k);
    endtask
    task done;
        $display("test %0d done", tn);
        tn++;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (90000) @(posedge mclk);
        n_mismatch++;
        close_out;
    end
    initial begin
        mclk = 1'b0;
        arst_n = 1'b0;
        {avs_read, avs_write, go, inc_enable, dir_enable, sls_enable} = '0;
        {dir_right_input, dir_left_input, ramp_fault_in} = 3'h0;
        avs_address = 6'h00;
        avs_writedata = 32'h0;
        spd_set = 16'h0000;
        rsrc = 3'h0;
        be = 4'hF;
        n_mismatch = 0;
        checked = 0;
        tn = 0;
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        rc(ASM_OFS_CTRL, ASM_CFG_RST);
        rc(ASM_OFS_STAT, 32'h0);
        rc(ASM_OFS_INTG, 32'h0);
        rc(6'h3C, 32'h0);
        wr(ASM_OFS_STAT, 32'hFFFF_FFFF);
        rc(ASM_OFS_STAT, 32'h0);
        be <= 4'h1;
        wr(ASM_OFS_STEP, 32'hFFFF_FF07);
        be <= 4'hF;
        rc(ASM_OFS_STEP, 32'h7);
        wr(ASM_OFS_STEP, 32'h14);
        rc(ASM_OFS_STEP, 32'h14);
        done;
        wr(ASM_OFS_XI, 32'h4);
        inc_enable <= 1'b1;
        dir_right_input <= 1'b1;
        smp(16'h0005, 2);
        cb(inc_ok, 1'b1);
        rc(ASM_OFS_TRV, 32'hA);
        smp(16'h0005, 2);
        cb(inc_ok, 1'b1);
        smp(16'h0005, 1);
        cb(inc_ok, 1'b0);
        pulse(3'h4);
        rb(3, 1'b1);
        clr(3'h4);
        rb(3, 1'b0);
        done;
        inc_enable <= 1'b1;
        dir_right_input <= 1'b1;
        smp(16'hFFFE, 2);
        rb(3, 1'b0);
        smp(16'hFFFE, 1);
        rb(3, 1'b1);
        clr(3'h2);
        done;
        wr(ASM_OFS_DSPD, 32'h5);
        wr(ASM_OFS_DPOS, 32'h5);
        dir_enable <= 1'b1;
        dir_left_input <= 1'b1;
        smp(16'hFFF9, 2);
        cb(dir_ok, 1'b1);
        smp(16'h0003, 1);
        cb(dir_ok, 1'b1);
        smp(16'h0009, 1);
        cb(dir_ok, 1'b0);
        rb(4, 1'b1);
        clr(3'h1);
        done;
        dir_enable <= 1'b1;
        {dir_right_input, dir_left_input} <= 2'h3;
        smp(16'h0000, 1);
        cb(alarm, 1'b1);
        clr(3'h4);
        done;
        wr(ASM_OFS_THR, 32'h32);
        sls_enable <= 1'b1;
        smp(16'h0031, 2);
        cb(sls_ok, 1'b1);
        smp(16'h0032, 1);
        cb(sls_ok, 1'b0);
        clr(3'h2);
        wr(ASM_OFS_THR, 32'h64);
        wr(ASM_OFS_ACC, 32'h3C);
        wr(ASM_OFS_CTRL, 32'h2);
        sls_enable <= 1'b1;
        smp(16'h0032, 1);
        smp(16'h0037, 1);
        cb(sls_ok, 1'b1);
        smp(16'hFFF6, 1);
        cb(sls_ok, 1'b0);
        clr(3'h4);
        done;
        wr(ASM_OFS_THR, 32'h32);
        wr(ASM_OFS_DIST, 32'h1E);
        wr(ASM_OFS_CTRL, 32'h4);
        sls_enable <= 1'b1;
        smp(16'h003C, 2);
        rc(ASM_OFS_INTG, 32'h14);
        smp(16'h0028, 1);
        rc(ASM_OFS_INTG, 32'hA);
        smp(16'h003C, 2);
        cb(sls_ok, 1'b1);
        smp(16'h003C, 1);
        cb(sls_ok, 1'b0);
        clr(3'h1);
        wr(ASM_OFS_CTRL, 32'h6);
        sls_enable <= 1'b1;
        smp(16'h003C, 1);
        rb(5, 1'b1);
        clr(3'h2);
        done;
        wr(ASM_OFS_CTRL, 32'h8);
        sls_enable <= 1'b1;
        smp(16'h003C, 1);
        cb(ramp_activate, 1'b1);
        rb(5, 1'b0);
        smp(16'h001E, 1);
        cb(ramp_activate, 1'b0);
        ramp_fault_in <= 1'b1;
        smp(16'h003C, 1);
        ramp_fault_in <= 1'b0;
        rb(5, 1'b1);
        wr(ASM_OFS_THR, 32'h0);
        smp(16'h001E, 1);
        cb(estop, 1'b1);
        clr(3'h1);
        done;
        wr(ASM_OFS_THR, 32'h32);
        wr(ASM_OFS_CTRL, 32'h10);
        sls_enable <= 1'b1;
        smp(16'h001E, 1);
        cb(fast_out, 1'b1);
        smp(16'h0046, 1);
        cb(fast_out, 1'b0);
        clr(3'h2);
        wr(ASM_OFS_CTRL, 32'h1);
        smp(16'h000A, 2);
        cb(sls_ok, 1'b1);
        done;
        close_out;
    end
endmodule
